// *** rtl/ocsl_cfg.svh ***
// Operation
// - Slave address confined to 0x08 through 0x0F
// - Address bit three fixed one, low three programmable
// - Trial registers cleared at valid supply
// - OTP supply high loads factory defaults
// - Keep clear, fuse select and all ten load bits set loads fuses
// - Keep and select clear leaves registers zero
// - Keep bit resets zero; set keeps values
// - Host writes trial registers, device stores them
// - Trial power-up needs supply, pin low, keep, event
// - Loaded fuses plus turn-on powers from fuses
// - Error-corrected fuse values loadable as option
// - Fuse array is ten banks of 26
// - Untrimmed 32 kHz only in three cases
// - Divided 32 kHz for start-up and debounce
// - ON-mode debounce divided; two interrupts untrimmed
// - 2 MHz switching clock divided from 20 MHz
// - User trim offset steps of one clock, ten percent
// - Edge select zero level, one edge, 4 s off
`ifndef OCSL_CFG_SVH
`define OCSL_CFG_SVH

// Fuse array shape
`define OCSL_BANKS 10
`define OCSL_BANK_W 26
// Slave address fixed upper bits
`define OCSL_ADDR_HI 4'h1
// Clock rate in kHz
`define OCSL_MCLK_KHZ 20000
// Divided low clock and switching clock rates in kHz
`define OCSL_SLOW_KHZ 32
`define OCSL_SW_KHZ 2000
// Long-press off time in ms
`define OCSL_LONG_MS 4000
// Default trim code
`define OCSL_TRIM_RST 5'h10

`endif

// *** rtl/ocsl_pkg.sv ***
`default_nettype none
package ocsl_pkg;
    // Load flow states
    typedef enum logic [2:0] {
        OCSL_IDLE,
        OCSL_LOAD,
        OCSL_DONE
    } ocsl_state_t;
    // Source of loaded contents
    typedef enum logic [1:0] {
        OCSL_SRC_NONE,
        OCSL_SRC_FUSE,
        OCSL_SRC_TRIAL,
        OCSL_SRC_FACT
    } ocsl_src_t;
endpackage : ocsl_pkg
`default_nettype wire

// *** rtl/ocsl_mem.sv ***
`include "ocsl_cfg.svh"
`default_nettype none
// Trial register bank, one word per bank, registered read data
module ocsl_mem #(
    parameter int DEPTH = `OCSL_BANKS,
    parameter int WIDTH = `OCSL_BANK_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Write side
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    // Read side
    input wire logic [3:0] rd_idx,
    output logic [WIDTH-1:0] rd_data
);
    // Storage words
    logic [WIDTH-1:0] mem_r [DEPTH];

    // Per-entry storage; cleared on reset
    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_word
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    mem_r[i] <= '0;
                end else if (wr_en && wr_idx == 4'(i)) begin
                    mem_r[i] <= wr_data;
                end
            end
        end
    endgenerate

    // Registered read port
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rd_data <= '0;
        end else if (int'(rd_idx) < DEPTH) begin
            rd_data <= mem_r[rd_idx];
        end else begin
            rd_data <= '0;
        end
    end
endmodule : ocsl_mem
`default_nettype wire

// *** rtl/ocsl_clkdiv.sv ***
`include "ocsl_cfg.svh"
`default_nettype none
// Free-running divider giving a one-cycle tick at a target rate
module ocsl_clkdiv #(
    parameter int DIV = 2
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Trim offset applied to the period
    input wire logic signed [5:0] adj,
    // Tick output
    output logic tick
);
    // Period counter
    logic [15:0] cnt_r;
    logic [15:0] top;

    // Trimmed terminal count
    assign top = 16'(DIV - 1 + int'(adj));

    // Counter and tick
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else if (cnt_r >= top) begin
            cnt_r <= '0;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule : ocsl_clkdiv
`default_nettype wire

// *** rtl/ocsl_loader.sv ***
`include "ocsl_cfg.svh"
`default_nettype none
// Start-up configuration source loader
module ocsl_loader #(
    parameter int BANKS = `OCSL_BANKS,
    parameter int BANK_W = `OCSL_BANK_W,
    parameter int LONG_MS = `OCSL_LONG_MS
) (
    // Clock and reset (reset = valid main supply first applied)
    input wire logic mclk,
    input wire logic sys_rst,
    // Source selection
    input wire logic otp_supply_pin,
    input wire logic trial_keep_bit_wr,
    input wire logic trial_keep_bit_val,
    input wire logic fuse_load_select_bit,
    input wire logic [BANKS-1:0] fuse_load_bits,
    input wire logic ecc_load_en,
    // Fuse array and factory defaults
    input wire logic [BANKS*BANK_W-1:0] fuse_raw,
    input wire logic [BANKS*BANK_W-1:0] fuse_ecc,
    input wire logic [BANKS*BANK_W-1:0] factory_cfg,
    // Host register writes
    input wire logic host_wr,
    input wire logic [3:0] host_idx,
    input wire logic [BANK_W-1:0] host_data,
    input wire logic [3:0] rd_idx,
    // Slave address match
    input wire logic [2:0] addr_prog,
    input wire logic [6:0] bus_addr,
    input wire logic bus_addr_vld,
    // Power events and operating conditions
    input wire logic main_supply_ok,
    input wire logic power_on_pin,
    input wire logic button_edge_select_bit,
    input wire logic all_sleep,
    input wire logic all_pfm,
    input wire logic on_mode,
    input wire logic signed [5:0] trim_offset,
    // Results
    output logic [BANK_W-1:0] rd_data,
    output logic [6:0] slave_address_field,
    output logic addr_ack,
    output logic [1:0] load_source,
    output logic load_done,
    output logic power_up,
    output logic power_off,
    output logic use_untrimmed,
    output logic debounce_divided,
    output logic irq_untrimmed,
    output logic sw_clk_tick,
    output logic slow_tick
);
    ///////////////////////////////////////////////////////////////////////////
    // Reset doubles as the valid-supply event that clears the trial words
    // Timing constants
    localparam int SLOW_DIV = `OCSL_MCLK_KHZ / `OCSL_SLOW_KHZ;
    localparam int SW_DIV = `OCSL_MCLK_KHZ / `OCSL_SW_KHZ;
    // Long press measured in divided slow ticks
    localparam int LONG_TICKS = LONG_MS * `OCSL_SLOW_KHZ;

    // State and internals
    ocsl_pkg::ocsl_state_t st_r;
    logic keep_r;
    logic [3:0] idx_r;
    // Trial storage write port
    logic mem_wr;
    logic [3:0] mem_idx;
    logic [BANK_W-1:0] mem_data;
    logic [BANK_W-1:0] fuse_word;
    // Button sampling and long-press count
    logic pin_d_r;
    logic [17:0] press_r;
    logic turn_on;
    // Raw divider ticks
    logic slow_t;
    logic sw_t;
    // Fuse source latched at the end of the walk
    logic loaded_fuse_r;

    ///////////////////////////////////////////////////////////////////////////
    // Keep bit, resets to zero
    // Written by a one-cycle strobe from the host
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            keep_r <= 1'b0;
        end else if (trial_keep_bit_wr) begin
            keep_r <= trial_keep_bit_val;
        end
    end

    // Source decode from pin and control bits
    // Decoded every cycle, so a later keep write needs no reload
    // Priority: supply pin, then keep, then fuse select
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            load_source <= ocsl_pkg::OCSL_SRC_NONE;
        end else if (otp_supply_pin) begin
            load_source <= ocsl_pkg::OCSL_SRC_FACT;
        end else if (keep_r) begin
            load_source <= ocsl_pkg::OCSL_SRC_TRIAL;
        end else if (fuse_load_select_bit && (&fuse_load_bits)) begin
            load_source <= ocsl_pkg::OCSL_SRC_FUSE;
        end else begin
            load_source <= ocsl_pkg::OCSL_SRC_NONE;
        end
    end

    ///////////////////////////////////////////////////////////////////////////
    // Corrected words only matter when correction was on at burn time
    // optional corrected fuse word; bank select
    always_comb begin
        fuse_word = ecc_load_en ? fuse_ecc[idx_r*BANK_W +: BANK_W]
                                : fuse_raw[idx_r*BANK_W +: BANK_W];
    end

    // Write mux: loader walk has priority over host
    // Host index drives the port whenever the walk is not running
    always_comb begin
        mem_wr = 1'b0;
        mem_idx = host_idx;
        mem_data = host_data;
        if (st_r == ocsl_pkg::OCSL_LOAD) begin
            mem_idx = idx_r;
            if (load_source == ocsl_pkg::OCSL_SRC_FACT) begin
                mem_wr = 1'b1;
                mem_data = factory_cfg[idx_r*BANK_W +: BANK_W];
            end else if (load_source == ocsl_pkg::OCSL_SRC_FUSE) begin
                mem_wr = 1'b1;
                mem_data = fuse_word;
            end
        end else begin
            mem_wr = host_wr;
        end
    end

    // Load walk over the banks, once after reset
    // One bank per clock; host writes are dropped while the walk runs
    // Hazard: source inputs must settle before reset is released
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r <= ocsl_pkg::OCSL_IDLE;
            idx_r <= '0;
            load_done <= 1'b0;
            loaded_fuse_r <= 1'b0;
        end else begin
            case (st_r)
                ocsl_pkg::OCSL_IDLE: begin
                    idx_r <= '0;
                    st_r <= ocsl_pkg::OCSL_LOAD;
                end
                ocsl_pkg::OCSL_LOAD: begin
                    if (int'(idx_r) == BANKS - 1) begin
                        st_r <= ocsl_pkg::OCSL_DONE;
                        load_done <= 1'b1;
                        loaded_fuse_r <= (load_source == ocsl_pkg::OCSL_SRC_FUSE);
                    end else begin
                        idx_r <= idx_r + 4'h1;
                    end
                end
                default: begin
                    // Stay done until the next supply restart
                    load_done <= 1'b1;
                end
            endcase
        end
    end

    // Trial register storage
    // Read data lags the read index by one clock
    ocsl_mem #(
        .DEPTH(BANKS),
        .WIDTH(BANK_W)
    ) u_mem (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .wr_en(mem_wr),
        .wr_idx(mem_idx),
        .wr_data(mem_data),
        .rd_idx(rd_idx),
        .rd_data(rd_data)
    );

    ///////////////////////////////////////////////////////////////////////////
    // Slave address and match
    // Upper bits are wired, so the address cannot leave its range
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            slave_address_field <= {`OCSL_ADDR_HI, 3'h0};
            addr_ack <= 1'b0;
        end else begin
            slave_address_field <= {`OCSL_ADDR_HI, addr_prog};
            addr_ack <= bus_addr_vld && (bus_addr == {`OCSL_ADDR_HI, addr_prog});
        end
    end

    ///////////////////////////////////////////////////////////////////////////
    // Divided clocks; switching clock trimmed by user offset
    // Slow divider carries no trim; it times the long press and drives slow_tick
    ocsl_clkdiv #(
        .DIV(SLOW_DIV)
    ) u_slow (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .adj(6'sh00),
        .tick(slow_t)
    );

    ocsl_clkdiv #(
        .DIV(SW_DIV)
    ) u_sw (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .adj(trim_offset),
        .tick(sw_t)
    );

    // Tick outputs registered
    // Extra stage keeps every output straight from a flip-flop
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            slow_tick <= 1'b0;
            sw_clk_tick <= 1'b0;
        end else begin
            slow_tick <= slow_t;
            sw_clk_tick <= sw_t;
        end
    end

    // Clock source selection flags
    // Untrimmed clock only for a low supply, all rails asleep or all rails in pulse mode
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            use_untrimmed <= 1'b0;
            debounce_divided <= 1'b0;
            irq_untrimmed <= 1'b1;
        end else begin
            use_untrimmed <= !main_supply_ok || all_sleep || all_pfm;
            debounce_divided <= (main_supply_ok && !load_done) ||
                                button_edge_select_bit || on_mode;
            irq_untrimmed <= 1'b1;
        end
    end

    ///////////////////////////////////////////////////////////////////////////
    // Power-on pin: level or falling edge, long-press off
    // Count clears whenever the pin is high or level mode is chosen
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_d_r <= 1'b0;
            press_r <= '0;
            power_off <= 1'b0;
        end else begin
            pin_d_r <= power_on_pin;
            if (!button_edge_select_bit || power_on_pin) begin
                press_r <= '0;
                power_off <= !button_edge_select_bit && !power_on_pin;
            end else if (int'(press_r) >= LONG_TICKS) begin
                power_off <= 1'b1;
            end else if (slow_t) begin
                press_r <= press_r + 18'h00001;
            end
        end
    end

    // Delayed pin resets low, so no false press follows reset
    // level high or falling edge turns on
    assign turn_on = button_edge_select_bit ? (pin_d_r && !power_on_pin) : power_on_pin;

    // Power-up decision
    // A turn-on event wins over a pending power-off
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            power_up <= 1'b0;
        end else if (main_supply_ok && load_done && turn_on) begin
            if (load_source == ocsl_pkg::OCSL_SRC_TRIAL && !otp_supply_pin) begin
                power_up <= 1'b1;
            end else if (loaded_fuse_r ||
                         load_source == ocsl_pkg::OCSL_SRC_FACT) begin
                power_up <= 1'b1;
            end
        end else if (power_off) begin
            // Long press or level low drops the rails
            power_up <= 1'b0;
        end
    end
endmodule : ocsl_loader
`default_nettype wire

// *** verif/ocsl_monitor.sv ***
`default_nettype none
// Ties loader outputs to their causes
module ocsl_monitor #(
    parameter int BANKS = 10
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Causes
    input wire logic otp_supply_pin,
    input wire logic fuse_load_select_bit,
    input wire logic [BANKS-1:0] fuse_load_bits,
    input wire logic [2:0] addr_prog,
    input wire logic [6:0] bus_addr,
    input wire logic bus_addr_vld,
    input wire logic main_supply_ok,
    input wire logic button_edge_select_bit,
    input wire logic all_sleep,
    input wire logic all_pfm,
    input wire logic signed [5:0] trim_offset,
    // Effects
    input wire logic [6:0] slave_address_field,
    input wire logic addr_ack,
    input wire logic [1:0] load_source,
    input wire logic load_done,
    input wire logic use_untrimmed,
    input wire logic debounce_divided,
    input wire logic irq_untrimmed,
    input wire logic sw_clk_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    // Nine quiet cycles between switching ticks
    sequence s_quiet; (!sw_clk_tick)[*8] ##1 !sw_clk_tick; endsequence
    // Load finished with the supply pin low
    sequence s_low_done; $rose(load_done) && !otp_supply_pin; endsequence
    property p_low;
        $stable(addr_prog) |=> slave_address_field == {4'h1, $past(addr_prog)};
    endproperty
    property p_ack; bus_addr_vld && bus_addr == slave_address_field |=> addr_ack; endproperty
    property p_cause;
        addr_ack |-> $past(bus_addr_vld) && $past(bus_addr) == {4'h1, $past(addr_prog)};
    endproperty
    property p_fact; $rose(load_done) && otp_supply_pin |-> load_source == 2'h3; endproperty
    property p_fuse;
        s_low_done |-> load_source == (fuse_load_select_bit && &fuse_load_bits ? 2'h1 : 2'h0);
    endproperty
    property p_unt;
        use_untrimmed |-> !$past(main_supply_ok) || $past(all_sleep) || $past(all_pfm);
    endproperty
    property p_deb; button_edge_select_bit |=> debounce_divided; endproperty
    property p_irq; irq_untrimmed; endproperty
    property p_sw; sw_clk_tick && trim_offset == 6'sh00 |=> s_quiet ##1 sw_clk_tick; endproperty
    a_low: assert property (p_low) else $error("address low bits");
    a_ack: assert property (p_ack) else $error("no answer");
    a_cause: assert property (p_cause) else $error("stray answer");
    a_fact: assert property (p_fact) else $error("not factory");
    a_fuse: assert property (p_fuse) else $error("bad low source");
    a_unt: assert property (p_unt) else $error("untrimmed misuse");
    a_deb: assert property (p_deb) else $error("not divided");
    a_irq: assert property (p_irq) else $error("irq clock");
    a_sw: assert property (p_sw) else $error("tick spacing");
endmodule : ocsl_monitor
bind ocsl_loader ocsl_monitor #(.BANKS(BANKS)) u_mon (.mclk, .sys_rst, .otp_supply_pin,
    .fuse_load_select_bit, .fuse_load_bits, .addr_prog, .bus_addr, .bus_addr_vld,
    .main_supply_ok, .button_edge_select_bit, .all_sleep, .all_pfm, .trim_offset,
    .slave_address_field, .addr_ack, .load_source, .load_done, .use_untrimmed,
    .debounce_divided, .irq_untrimmed, .sw_clk_tick);
`default_nettype wire

// *** verif/ocsl_host_model.sv ***
`default_nettype none
// Host master: trial word writes and address probes
module ocsl_host_model (
    // Clock
    input wire logic mclk,
    // Write request
    output logic host_wr,
    output logic [3:0] host_idx,
    output logic [25:0] host_data,
    // Address probe
    output logic [6:0] bus_addr,
    output logic bus_addr_vld,
    input wire logic addr_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus
    initial begin
        {host_wr, host_idx, host_data, bus_addr, bus_addr_vld} = '0;
    end
    // one word a cycle; gap zero keeps the strobe up
    task automatic wr(input logic [3:0] i, input logic [25:0] d, input int gap);
        host_wr = 1'b1;
        host_idx = i;
        host_data = d;
        @(negedge mclk);
        if (gap > 0) begin
            host_wr = 1'b0;
            host_data = ~d;
            repeat (gap) @(negedge mclk);
        end
    endtask : wr
    // Probe one address; answer comes a cycle later
    task automatic probe(input logic [6:0] a, output logic ack);
        bus_addr = a;
        bus_addr_vld = 1'b1;
        @(negedge mclk);
        ack = addr_ack;
        bus_addr_vld = 1'b0;
        bus_addr = ~a;
        @(negedge mclk);
    endtask : probe
endmodule : ocsl_host_model
`default_nettype wire

// *** verif/tb_top.sv ***
`default_nettype none
// Self-checking bench for the loader
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // Design inputs
    logic mclk, sys_rst, otp_supply_pin, trial_keep_bit_wr, trial_keep_bit_val, ecc_load_en;
    logic fuse_load_select_bit, main_supply_ok, power_on_pin, button_edge_select_bit;
    logic all_sleep, all_pfm, on_mode, host_wr, bus_addr_vld;
    logic [9:0] fuse_load_bits;
    logic [259:0] fuse_raw, fuse_ecc, factory_cfg;
    logic [3:0] rd_idx, host_idx;
    logic [25:0] host_data, rd_data;
    logic [2:0] addr_prog, flags;
    logic [6:0] bus_addr, slave_address_field;
    logic signed [5:0] trim_offset;
    // Design outputs
    logic addr_ack, load_done, power_up, power_off, use_untrimmed, debounce_divided;
    logic irq_untrimmed, sw_clk_tick, slow_tick, ack;
    logic [1:0] load_source, ticks;
    int n_errors, checks, n;
    assign flags = {power_off, power_up, load_done};
    assign ticks = {slow_tick, sw_clk_tick};
    ////////////////////////////////////////
    ocsl_loader #(.LONG_MS(1)) dut (.mclk, .sys_rst, .otp_supply_pin, .trial_keep_bit_wr,
        .trial_keep_bit_val, .fuse_load_select_bit, .fuse_load_bits, .ecc_load_en, .fuse_raw,
        .fuse_ecc, .factory_cfg, .host_wr, .host_idx, .host_data, .rd_idx, .addr_prog,
        .bus_addr, .bus_addr_vld, .main_supply_ok, .power_on_pin, .button_edge_select_bit,
        .all_sleep, .all_pfm, .on_mode, .trim_offset, .rd_data, .slave_address_field,
        .addr_ack, .load_source, .load_done, .power_up, .power_off, .use_untrimmed,
        .debounce_divided, .irq_untrimmed, .sw_clk_tick, .slow_tick);
    ocsl_host_model host (.mclk, .host_wr, .host_idx, .host_data, .bus_addr, .bus_addr_vld,
        .addr_ack);
    ////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    // Bounded wait on load done, power up or power off
    task automatic wait_on(input int sel, input int lim);
        for (n = 0; n < lim && flags[sel] !== 1'b1; n++)
            @(negedge mclk);
        check(flags[sel], 1);
        if (flags[sel] !== 1'b1) begin
            give_verdict();
        end
    endtask : wait_on
    // Cycles from one divider tick to the next
    task automatic period(input int sel);
        for (n = 0; n < 700 && ticks[sel] !== 1'b1; n++)
            @(negedge mclk);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (n < 700 && ticks[sel] !== 1'b1);
    endtask : period
    // Expected bank word per source: 0 factory, 1 fuse, 2 corrected, else none
    function automatic logic [25:0] word(input int m, input int i);
        if (i > 9 || m > 2) return 26'h0;
        return (m == 0 ? 26'h2AAAA00 : m == 1 ? 26'h1555500 : 26'h0F0F000) + 26'(i);
    endfunction : word
    task automatic rd(input int i, input logic [25:0] e);
        rd_idx = 4'(i);
        @(negedge mclk);
        check(rd_data, e);
    endtask : rd
    // Supply restart with one source selection (4 is a partial fuse mask)
    task automatic restart(input int m);
        otp_supply_pin = (m == 0);
        fuse_load_select_bit = (m == 1 || m == 2 || m == 4);
        // every fuse load bit set, one left clear in case 4
        fuse_load_bits = (m == 4) ? 10'h1FF : 10'h3FF;
        ecc_load_en = (m == 2);
        sys_rst = 1'b1;
        repeat (12) @(negedge mclk);
        sys_rst = 1'b0;
        wait_on(0, 40);
    endtask : restart
    ////////////////////////////////////////
    initial begin
        {n_errors, checks, trial_keep_bit_wr, trial_keep_bit_val, all_sleep, all_pfm} = '0;
        {on_mode, button_edge_select_bit, rd_idx, addr_prog, trim_offset} = '0;
        {main_supply_ok, power_on_pin} = 2'h3;
        for (int i = 0; i < 10; i++) begin
            factory_cfg[i*26 +: 26] = word(0, i);
            fuse_raw[i*26 +: 26] = word(1, i);
            fuse_ecc[i*26 +: 26] = word(2, i);
        end
        // Factory, fuse, corrected, none and partial mask; every bank plus one past the end
        for (int m = 0; m < 5; m++) begin
            restart(m);
            check(load_source, m == 0 ? 3 : m < 3 ? 1 : 0);
            for (int i = 0; i < 11; i++)
                rd(i, word(m, i));
            check(power_up, m < 3);
        end
        host.wr(4'h3, 26'h3ABCDEF, 0);
        host.wr(4'h9, 26'h0123456, 1);
        rd(3, 26'h3ABCDEF);
        rd(9, 26'h0123456);
        // Keep bit set: trial contents power the device
        {trial_keep_bit_wr, trial_keep_bit_val} = 2'h3;
        @(negedge mclk);
        trial_keep_bit_wr = 1'b0;
        wait_on(1, 20);
        rd(3, 26'h3ABCDEF);
        for (int p = 0; p < 8; p++) begin
            addr_prog = 3'(p);
            repeat (2) @(negedge mclk);
            check(slave_address_field, 8 + p);
            host.probe(7'(8 + p), ack);
            check(ack, 1);
            host.probe(7'(8 + (p ^ 5)), ack);
            check(ack, 0);
        end
        // Clock choice: supply low, all asleep, all pulse mode, normal
        for (int c = 0; c < 4; c++) begin
            {all_pfm, all_sleep, main_supply_ok} = 3'(c == 0 ? 0 : c == 1 ? 3 : c == 2 ? 5 : 1);
            repeat (2) @(negedge mclk);
            check(use_untrimmed, c != 3);
        end
        on_mode = 1'b1;
        repeat (2) @(negedge mclk);
        check(debounce_divided, 1);
        check(irq_untrimmed, 1);
        // Level mode: pin low turns off, pin high turns on again
        power_on_pin = 1'b0;
        wait_on(2, 10);
        @(negedge mclk);
        check(power_up, 0);
        power_on_pin = 1'b1;
        wait_on(1, 10);
        {on_mode, button_edge_select_bit} = 2'h1;
        repeat (2) @(negedge mclk);
        check(debounce_divided, 1);
        period(0);
        check(n, 10);
        // One cycle of trim stretches the switching period by one
        trim_offset = 6'sh01;
        period(0);
        check(n, 11);
        trim_offset = 6'sh00;
        period(1);
        check(n, 625);
        // Edge mode: a long hold turns off, a release does not turn on, a press does
        power_on_pin = 1'b0;
        wait_on(2, 21000);
        power_on_pin = 1'b1;
        repeat (3) @(negedge mclk);
        check(power_up, 0);
        power_on_pin = 1'b0;
        wait_on(1, 20);
        repeat (19000) @(negedge mclk);
        check(power_off, 0);
        wait_on(2, 2000);
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
